// ==== shared/uig_pkg.sv ====
// constants and types for the serial port interrupt enable gating block
package uig_pkg;

    // ----------------------------------------
    // register map, byte addresses
    // ----------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_FLAGS = 8'h0C;

    // ----------------------------------------
    // field layout
    // ----------------------------------------
    localparam int EN_W = 3;
    localparam int EN_TX_EMPTY = 0;
    localparam int EN_TX_IDLE = 1;
    localparam int EN_RX = 2;
    localparam int SRC_W = 4;
    localparam int SRC_TX_EMPTY = 0;
    localparam int SRC_TX_IDLE = 1;
    localparam int SRC_RX_DATA = 2;
    localparam int SRC_RX_OVERRUN = 3;

    // ----------------------------------------
    // reset values and bus answers
    // ----------------------------------------
    localparam logic [EN_W-1:0] RST_ENABLE = 3'h0;
    localparam logic [SRC_W-1:0] RST_MASK = 4'h0;
    localparam logic [SRC_W-1:0] RST_STATUS = 4'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        WR_IDLE = 2'h1,
        WR_RESP = 2'h2
    } uig_wr_state_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'h1,
        RD_DATA = 2'h2
    } uig_rd_state_t;

endpackage

// ==== shared/uig_gate_if.sv ====
// enable and status signals between register core and gating logic
`timescale 1ns/1ns
interface uig_gate_if;
    logic [uig_pkg::EN_W-1:0] enable;
    logic [uig_pkg::SRC_W-1:0] flags;
    logic [uig_pkg::SRC_W-1:0] set_vec;

    // gating side sees enables and flags, returns the events to latch
    modport gate (
        input enable,
        input flags,
        output set_vec
    );

    modport core (
        output enable,
        output flags,
        input set_vec
    );
endinterface

// ==== rtl/uig_gate.sv ====
// per-source gating of serial port status flags by the interrupt enables
`timescale 1ns/1ns
module uig_gate (
    uig_gate_if.gate g
);

    // ----------------------------------------
    // map each source onto its enable bit
    // ----------------------------------------
    logic [uig_pkg::SRC_W-1:0] src_en;

    // both receiver sources share one enable
    always_comb begin
        src_en = '0;
        src_en[uig_pkg::SRC_RX_OVERRUN] = g.enable[uig_pkg::EN_RX];
        src_en[uig_pkg::SRC_RX_DATA] = g.enable[uig_pkg::EN_RX];
        src_en[uig_pkg::SRC_TX_IDLE] = g.enable[uig_pkg::EN_TX_IDLE];
        src_en[uig_pkg::SRC_TX_EMPTY] = g.enable[uig_pkg::EN_TX_EMPTY];
    end

    // ----------------------------------------
    // level gating, one lane per source
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < uig_pkg::SRC_W; i++) begin : g_lane
            // a disabled lane is forced low, so its flag cannot reach the request
            assign g.set_vec[i] = g.flags[i] & src_en[i];
        end
    endgenerate

endmodule

// ==== rtl/uig_irq_gating.sv ====
// serial port interrupt enable gating with an axi4-lite register slave
`timescale 1ns/1ns
module uig_irq_gating (
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    // axi4-lite write address
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [uig_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic [2:0] S_AXI_AWPROT,
    // axi4-lite write data
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    // axi4-lite write response
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    output logic [1:0] S_AXI_BRESP,
    // axi4-lite read address
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    input wire logic [uig_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic [2:0] S_AXI_ARPROT,
    // axi4-lite read data
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    // status flags from the serial port, same clock domain
    input wire logic RX_OVERRUN_FLAG,
    input wire logic RX_DATA_AVAILABLE_FLAG,
    input wire logic TX_IDLE_FLAG,
    input wire logic TX_EMPTY_FLAG,
    // interrupt request towards the interrupt controller
    output logic UART_IRQ
);

    // ----------------------------------------
    // state declarations
    // ----------------------------------------
    uig_pkg::uig_wr_state_t wr_state_ff;
    uig_pkg::uig_wr_state_t nxt_wr_state;
    uig_pkg::uig_rd_state_t rd_state_ff;
    uig_pkg::uig_rd_state_t nxt_rd_state;

    logic aw_got_ff;
    logic nxt_aw_got;
    logic w_got_ff;
    logic nxt_w_got;
    logic [uig_pkg::ADDR_W-1:0] wr_addr_ff;
    logic [uig_pkg::ADDR_W-1:0] nxt_wr_addr;
    logic [31:0] wr_data_ff;
    logic [31:0] nxt_wr_data;
    logic [3:0] wr_strb_ff;
    logic [3:0] nxt_wr_strb;
    logic [1:0] bresp_ff;
    logic [1:0] nxt_bresp;

    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [1:0] rresp_ff;
    logic [1:0] nxt_rresp;

    logic [uig_pkg::EN_W-1:0] enable_ff;
    logic [uig_pkg::EN_W-1:0] nxt_enable;
    logic [uig_pkg::SRC_W-1:0] mask_ff;
    logic [uig_pkg::SRC_W-1:0] nxt_mask;
    logic [uig_pkg::SRC_W-1:0] status_ff;
    logic [uig_pkg::SRC_W-1:0] nxt_status;
    logic irq_ff;
    logic nxt_irq;

    logic wr_fire;
    logic wr_hit;
    logic rd_take;
    logic [uig_pkg::SRC_W-1:0] flags_raw;
    logic [uig_pkg::SRC_W-1:0] clr_vec;

    // register write decode and aligned read address
    logic [uig_pkg::ADDR_W-1:0] rd_addr_al;
    logic wr_lane0;
    logic ctrl_we;
    logic mask_we;
    logic status_we;

    uig_gate_if gif ();

    // ----------------------------------------
    // gating of status flags by the enables
    // ----------------------------------------

    // flags come from logic on this clock, so no synchroniser is needed
    assign flags_raw[uig_pkg::SRC_RX_OVERRUN] = RX_OVERRUN_FLAG;
    assign flags_raw[uig_pkg::SRC_RX_DATA] = RX_DATA_AVAILABLE_FLAG;
    assign flags_raw[uig_pkg::SRC_TX_IDLE] = TX_IDLE_FLAG;
    assign flags_raw[uig_pkg::SRC_TX_EMPTY] = TX_EMPTY_FLAG;
    // hand flags and enables to the gating lanes
    assign gif.flags = flags_raw;
    assign gif.enable = enable_ff;

    uig_gate u_gate (
        .g (gif.gate)
    );

    // ----------------------------------------
    // write channel
    // ----------------------------------------

    // one write in flight; a new address waits until the response is taken
    // address and data may arrive in either order; each is held once taken
    assign S_AXI_AWREADY = (wr_state_ff == uig_pkg::WR_IDLE) && !aw_got_ff;
    assign S_AXI_WREADY = (wr_state_ff == uig_pkg::WR_IDLE) && !w_got_ff;
    assign S_AXI_BVALID = (wr_state_ff == uig_pkg::WR_RESP);
    assign S_AXI_BRESP = bresp_ff;

    // the write takes effect in the cycle after both halves are held
    assign wr_fire = (wr_state_ff == uig_pkg::WR_IDLE) && aw_got_ff && w_got_ff;
    assign wr_hit = (wr_addr_ff == uig_pkg::OFS_CTRL) || (wr_addr_ff == uig_pkg::OFS_STATUS)
        || (wr_addr_ff == uig_pkg::OFS_MASK);

    // next state of the write side
    always_comb begin
        nxt_wr_state = wr_state_ff;
        nxt_aw_got = aw_got_ff;
        nxt_w_got = w_got_ff;
        nxt_wr_addr = wr_addr_ff;
        nxt_wr_data = wr_data_ff;
        nxt_wr_strb = wr_strb_ff;
        nxt_bresp = bresp_ff;
        case (wr_state_ff)
            uig_pkg::WR_IDLE: begin
                if (wr_fire) begin
                    nxt_aw_got = 1'b0;
                    nxt_w_got = 1'b0;
                    nxt_bresp = wr_hit ? uig_pkg::RESP_OKAY : uig_pkg::RESP_SLVERR;
                    nxt_wr_state = uig_pkg::WR_RESP;
                end else begin
                    if (S_AXI_AWVALID && !aw_got_ff) begin
                        nxt_aw_got = 1'b1;
                        nxt_wr_addr = {S_AXI_AWADDR[uig_pkg::ADDR_W-1:2], 2'h0};
                    end
                    if (S_AXI_WVALID && !w_got_ff) begin
                        nxt_w_got = 1'b1;
                        nxt_wr_data = S_AXI_WDATA;
                        nxt_wr_strb = S_AXI_WSTRB;
                    end
                end
            end
            uig_pkg::WR_RESP: begin
                if (S_AXI_BREADY) begin
                    nxt_wr_state = uig_pkg::WR_IDLE;
                end
            end
            default: begin
                nxt_wr_state = uig_pkg::WR_IDLE;
                nxt_aw_got = 1'b0;
                nxt_w_got = 1'b0;
            end
        endcase
    end

    // write side registers
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wr_state_ff <= uig_pkg::WR_IDLE;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            wr_addr_ff <= '0;
            wr_data_ff <= '0;
            wr_strb_ff <= '0;
            bresp_ff <= uig_pkg::RESP_OKAY;
        end else begin
            wr_state_ff <= nxt_wr_state;
            aw_got_ff <= nxt_aw_got;
            w_got_ff <= nxt_w_got;
            wr_addr_ff <= nxt_wr_addr;
            wr_data_ff <= nxt_wr_data;
            wr_strb_ff <= nxt_wr_strb;
            bresp_ff <= nxt_bresp;
        end
    end

    // ----------------------------------------
    // read channel
    // ----------------------------------------
    // one read in flight; arready stays low while the data stands
    assign S_AXI_ARREADY = (rd_state_ff == uig_pkg::RD_IDLE);
    assign S_AXI_RVALID = (rd_state_ff == uig_pkg::RD_DATA);
    assign S_AXI_RDATA = rdata_ff;
    assign S_AXI_RRESP = rresp_ff;
    assign rd_take = S_AXI_ARVALID && (rd_state_ff == uig_pkg::RD_IDLE);

    // low address bits are dropped, so an unaligned read hits the word below
    assign rd_addr_al = {S_AXI_ARADDR[uig_pkg::ADDR_W-1:2], 2'h0};

    // read data is captured when the address is taken and held until rready
    always_comb begin
        nxt_rd_state = rd_state_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        case (rd_state_ff)
            uig_pkg::RD_IDLE: begin
                if (rd_take) begin
                    nxt_rd_state = uig_pkg::RD_DATA;
                    nxt_rresp = uig_pkg::RESP_OKAY;
                    nxt_rdata = '0;
                    case (rd_addr_al)
                        uig_pkg::OFS_CTRL: nxt_rdata[uig_pkg::EN_W-1:0] = enable_ff;
                        uig_pkg::OFS_STATUS: nxt_rdata[uig_pkg::SRC_W-1:0] = status_ff;
                        uig_pkg::OFS_MASK: nxt_rdata[uig_pkg::SRC_W-1:0] = mask_ff;
                        uig_pkg::OFS_FLAGS: nxt_rdata[uig_pkg::SRC_W-1:0] = flags_raw;
                        default: nxt_rresp = uig_pkg::RESP_SLVERR;
                    endcase
                end
            end
            uig_pkg::RD_DATA: begin
                if (S_AXI_RREADY) begin
                    nxt_rd_state = uig_pkg::RD_IDLE;
                end
            end
            default: begin
                nxt_rd_state = uig_pkg::RD_IDLE;
            end
        endcase
    end

    // read side registers
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rd_state_ff <= uig_pkg::RD_IDLE;
            rdata_ff <= '0;
            rresp_ff <= uig_pkg::RESP_OKAY;
        end else begin
            rd_state_ff <= nxt_rd_state;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    // ----------------------------------------
    // enables, mask and sticky request status
    // ----------------------------------------

    // write decode; all fields live in byte lane 0, so only wstrb[0] matters
    assign wr_lane0 = wr_strb_ff[0];
    assign ctrl_we = wr_fire && wr_lane0 && (wr_addr_ff == uig_pkg::OFS_CTRL);
    assign mask_we = wr_fire && wr_lane0 && (wr_addr_ff == uig_pkg::OFS_MASK);
    assign status_we = wr_fire && wr_lane0 && (wr_addr_ff == uig_pkg::OFS_STATUS);

    // next enables, mask and status; a dropped enable leaves a latched bit set until software clears it
    always_comb begin
        nxt_enable = enable_ff;
        nxt_mask = mask_ff;
        clr_vec = '0;
        if (ctrl_we) begin
            nxt_enable = wr_data_ff[uig_pkg::EN_W-1:0];
        end
        if (mask_we) begin
            nxt_mask = wr_data_ff[uig_pkg::SRC_W-1:0];
        end
        if (status_we) begin
            clr_vec = wr_data_ff[uig_pkg::SRC_W-1:0];
        end
        // set wins over a same-cycle write-one-to-clear, so no event is lost
        nxt_status = (status_ff & ~clr_vec) | gif.set_vec;
    end

    // enable, mask and status registers
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            enable_ff <= uig_pkg::RST_ENABLE;
            mask_ff <= uig_pkg::RST_MASK;
            status_ff <= uig_pkg::RST_STATUS;
        end else begin
            enable_ff <= nxt_enable;
            mask_ff <= nxt_mask;
            status_ff <= nxt_status;
        end
    end

    // ----------------------------------------
    // interrupt request
    // ----------------------------------------

    // disabled sources never reach the set vector, so only the mask is applied here
    // level output: high until every unmasked status bit is cleared
    always_comb begin
        nxt_irq = |(status_ff & mask_ff);
    end

    // registered irq: one cycle behind status, but glitch-free at the pin
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
        end
    end

    assign UART_IRQ = irq_ff;

endmodule

// ==== tb/uig_irq_gating_assertions.sv ====
// assertion checker for the interrupt enable gating block
`timescale 1ns/1ns
module uig_irq_gating_assertions (
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic [uig_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic RX_OVERRUN_FLAG,
    input wire logic RX_DATA_AVAILABLE_FLAG,
    input wire logic TX_IDLE_FLAG,
    input wire logic TX_EMPTY_FLAG,
    input wire logic UART_IRQ
);
    logic [7:0] adr_ff;
    logic [4:0] dat_ff;
    logic [2:0] en_ff;
    logic [3:0] mk_ff;
    logic idle;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);
    // shadow lags the design, so it is trusted only while no response is out
    assign idle = !S_AXI_BVALID;
    // shadow of enables and mask, taken at the write response
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            adr_ff <= 8'h00;
            dat_ff <= 5'h00;
            en_ff <= 3'h0;
            mk_ff <= 4'h0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) adr_ff <= S_AXI_AWADDR;
            if (S_AXI_WVALID && S_AXI_WREADY) dat_ff <= {S_AXI_WSTRB[0], S_AXI_WDATA[3:0]};
            if (S_AXI_BVALID && S_AXI_BREADY && dat_ff[4]) begin
                if (adr_ff[7:2] == uig_pkg::OFS_CTRL[7:2]) en_ff <= dat_ff[2:0];
                if (adr_ff[7:2] == uig_pkg::OFS_MASK[7:2]) mk_ff <= dat_ff[3:0];
            end
        end
    end
    a_rx_irq_raise: assert property (
        (idle && en_ff[2] && ((mk_ff[3] && RX_OVERRUN_FLAG) || (mk_ff[2] && RX_DATA_AVAILABLE_FLAG)))
        ##1 idle |=> UART_IRQ) else $error("rx irq missing");
    a_rx_irq_quiet: assert property (
        (idle && !en_ff[2] && mk_ff[1:0] == 2'h0 && mk_ff[3:2] != 2'h0) ##1 idle |=> $stable(UART_IRQ))
        else $error("disabled rx moved irq");
    a_idle_irq_raise: assert property (
        (idle && en_ff[1] && mk_ff[1] && TX_IDLE_FLAG) ##1 idle |=> UART_IRQ) else $error("idle irq missing");
    a_idle_irq_quiet: assert property (
        (idle && !en_ff[1] && mk_ff == 4'h2) ##1 idle |=> $stable(UART_IRQ)) else $error("disabled idle moved irq");
    a_empty_irq_raise: assert property (
        (idle && en_ff[0] && mk_ff[0] && TX_EMPTY_FLAG) ##1 idle |=> UART_IRQ) else $error("empty irq missing");
    a_empty_irq_quiet: assert property (
        (idle && !en_ff[0] && mk_ff == 4'h1) ##1 idle |=> $stable(UART_IRQ)) else $error("disabled empty moved irq");
endmodule
bind uig_irq_gating uig_irq_gating_assertions u_chk (.CORE_CLK, .ARST_N, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_AWADDR, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_BVALID, .S_AXI_BREADY,
    .RX_OVERRUN_FLAG, .RX_DATA_AVAILABLE_FLAG, .TX_IDLE_FLAG, .TX_EMPTY_FLAG, .UART_IRQ);

// ==== tb/test_uig_irq_gating.sv ====
// self-checking bench for the interrupt enable gating block
`timescale 1ns/1ns
module test_uig_irq_gating;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic awv = 1'b0;
    logic wv = 1'b0;
    logic br = 1'b0;
    logic arv = 1'b0;
    logic rr = 1'b0;
    logic ichk = 1'b0;
    logic [7:0] awa = 8'h00;
    logic [7:0] ara = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [3:0] fl = 4'h0;
    logic [3:0] ws = 4'hF;
    logic [7:0] lf = 8'h3B;
    logic awr, wrdy, bv, arr, rv, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdat;
    logic [33:0] rq[$];
    logic [33:0] bq[$];
    logic [33:0] iq[$];
    int checks = 0;
    int miscompares = 0;
    int cyc = 0;
    always #25 core_clk = ~core_clk;
    uig_irq_gating u_dut (.CORE_CLK(core_clk), .ARST_N(arst_n),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa), .S_AXI_AWPROT(3'h0),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws),
        .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_BRESP(bresp),
        .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara), .S_AXI_ARPROT(3'h0),
        .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp),
        .RX_OVERRUN_FLAG(fl[3]), .RX_DATA_AVAILABLE_FLAG(fl[2]), .TX_IDLE_FLAG(fl[1]),
        .TX_EMPTY_FLAG(fl[0]), .UART_IRQ(irq));
    // small lfsr for the random enables and flags
    function automatic logic [7:0] nx(logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    function automatic logic [33:0] ok(logic [31:0] d);
        return {uig_pkg::RESP_OKAY, d};
    endfunction
    function void cmp(string n, logic [33:0] e, logic [33:0] s);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endfunction
    // write: both channels offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = uig_pkg::RESP_OKAY);
        bq.push_back({32'h0, e});
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end while (!bv);
        br <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        rq.push_back(e);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rr <= 1'b0;
        @(posedge core_clk);
    endtask
    // one-cycle window in which the monitor samples the irq line
    task automatic ick(input logic e);
        iq.push_back({33'h0, e});
        ichk <= 1'b1;
        @(posedge core_clk);
        ichk <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic pulse(input int n);
        fl <= 4'h1 << n;
        repeat (2) @(posedge core_clk);
        fl <= 4'h0;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // monitor: oldest note against each answer as it is taken
    always @(posedge core_clk) begin
        if (rv && rr) cmp("read", rq.pop_front(), {rresp, rdat});
        if (bv && br) cmp("bresp", bq.pop_front(), {32'h0, bresp});
        if (ichk) cmp("irq", iq.pop_front(), {33'h0, irq});
    end
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        rd(uig_pkg::OFS_CTRL, ok(32'h0));
        rd(uig_pkg::OFS_STATUS, ok(32'h0));
        rd(uig_pkg::OFS_MASK, ok(32'h0));
        rd(8'h10, {uig_pkg::RESP_SLVERR, 32'h0});
        wr(8'h10, 32'hFFFFFFFF, uig_pkg::RESP_SLVERR);
        wr(uig_pkg::OFS_FLAGS, 32'hF, uig_pkg::RESP_SLVERR);
        // lane 0 strobe low: write accepted, enables keep their value
        ws <= 4'hE;
        wr(uig_pkg::OFS_CTRL, 32'h7);
        ws <= 4'hF;
        rd(uig_pkg::OFS_CTRL, ok(32'h0));
        $display("test reset done");
        // random enables read back; raw flags visible
        repeat (4) begin
            lf = nx(lf);
            fl <= lf[7:4];
            wr(uig_pkg::OFS_CTRL, {24'h0, lf});
            rd(uig_pkg::OFS_CTRL, ok({29'h0, lf[2:0]}));
            rd(uig_pkg::OFS_FLAGS, ok({28'h0, lf[7:4]}));
        end
        fl <= 4'h0;
        wr(uig_pkg::OFS_CTRL, 32'h0);
        wr(uig_pkg::OFS_STATUS, 32'hF);
        $display("test random done");
        // each source: disabled, enabled, masked, cleared
        for (int i = 0; i < 4; i++) begin
            wr(uig_pkg::OFS_MASK, 32'h1 << i);
            wr(uig_pkg::OFS_CTRL, 32'h0);
            pulse(i);
            ick(1'b0);
            rd(uig_pkg::OFS_STATUS, ok(32'h0));
            wr(uig_pkg::OFS_CTRL, 32'h1 << ((i > 1) ? 2 : i));
            pulse(i);
            ick(1'b1);
            rd(uig_pkg::OFS_STATUS, ok(32'h1 << i));
            wr(uig_pkg::OFS_MASK, 32'h0);
            ick(1'b0);
            wr(uig_pkg::OFS_MASK, 32'h1 << i);
            ick(1'b1);
            wr(uig_pkg::OFS_STATUS, 32'h1 << i);
            ick(1'b0);
            rd(uig_pkg::OFS_STATUS, ok(32'h0));
        end
        $display("test gating done");
        tally_and_finish();
    end
endmodule
